// *** shared/adc_fmt_pkg.sv ***
// Constants and types for the converter result and reference select block
package adc_fmt_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RES_LOW = 6'h04;
  localparam logic [IDX_W-1:0] IDX_RES_HIGH = 6'h05;
  localparam logic [IDX_W-1:0] IDX_SELECT = 6'h07;
  localparam logic [IDX_W-1:0] IDX_CSB = 6'h08;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h09;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h0A;
  // Selection register fields
  localparam int SEL_REF_MSB = 7;
  localparam int SEL_REF_LSB = 6;
  localparam int SEL_ALIGN = 5;
  localparam int SEL_CHAN_MSB = 4;
  // Control/status B fields
  localparam int CSB_BIN = 7;
  localparam int CSB_GAIN_HI = 6;
  localparam int CSB_REF_HIGH = 4;
  localparam int CSB_CHAN_MSB = 3;
  // Interrupt status fields
  localparam int ST_W = 2;
  localparam int ST_DONE = 0;
  localparam int ST_REF_UPD = 1;
  // Reset values
  localparam logic [7:0] RESET_SELECT = 8'h00;
  localparam logic [7:0] RESET_CSB = 8'h00;
  localparam logic [ST_W-1:0] RESET_STATUS = 2'h0;
  localparam logic [ST_W-1:0] RESET_MASK = 2'h0;
  // Conversion lengths in converter clocks
  localparam logic [4:0] CONV_NORMAL_CYC = 5'h0D;
  localparam logic [4:0] CONV_LONG_CYC = 5'h19;
  // Channel codes and result limits
  localparam logic [5:0] TEMP_CHANNEL = 6'h3F;
  localparam int RAW_W = 12;
  localparam logic signed [RAW_W-1:0] UNI_MAX = 12'h3FF;
  localparam logic signed [RAW_W-1:0] BIP_MAX = 12'h1FF;
  localparam logic signed [RAW_W-1:0] BIP_MIN = 12'hE00;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_MAX = 10'h3FF;
  localparam logic [9:0] CODE_BIP_MAX = 10'h1FF;
  localparam logic [9:0] CODE_BIP_MIN = 10'h200;

  typedef enum logic [1:0] {
    GAIN_1X = 2'b00,
    GAIN_8X = 2'b01,
    GAIN_20X = 2'b10,
    GAIN_32X = 2'b11
  } gain_t;

  typedef enum logic [1:0] {
    KIND_SINGLE = 2'b00,
    KIND_UNIPOLAR = 2'b01,
    KIND_BIPOLAR = 2'b10
  } conv_kind_t;

  typedef enum logic [2:0] {
    REF_SUPPLY = 3'b000,
    REF_EXT_PIN = 3'b001,
    REF_INT_1V1 = 3'b010,
    REF_RESERVED = 3'b011,
    REF_INT_2V56 = 3'b100,
    REF_INT_2V56_BYP = 3'b101
  } ref_src_t;
endpackage

// *** shared/chan_if.sv ***
// Channel code and its decoded input kind and gain
`timescale 1ns/1ns
interface chan_if;
  import adc_fmt_pkg::*;
  logic [5:0] code;
  logic gain_hi;
  logic diff;
  gain_t gain;
  logic temp;
  modport decoder (input code, input gain_hi, output diff, output gain, output temp);
  modport user (output code, output gain_hi, input diff, input gain, input temp);
endinterface

// *** hw/channel_decode.sv ***
// Decode of the six-bit channel code into input kind and gain
`timescale 1ns/1ns
module channel_decode
  import adc_fmt_pkg::*;
(
  // Channel code and decoded fields
  chan_if.decoder ch
);
  logic is_diff;
  logic low_gain;

  always_comb begin
    is_diff = 1'b0;
    low_gain = 1'b0;
    if (ch.code >= 6'h0B && ch.code <= 6'h1D) begin
      is_diff = 1'b1;
      // Pairs that run at the low gain
      unique case (ch.code)
        6'h0C, 6'h0F, 6'h10, 6'h13, 6'h15, 6'h18, 6'h1A, 6'h1D: low_gain = 1'b1;
        default: low_gain = 1'b0;
      endcase
    end else if (ch.code >= 6'h20 && ch.code <= 6'h3D) begin
      is_diff = 1'b1;
      low_gain = ch.code[0] && (ch.code < 6'h3A);
    end
    ch.diff = is_diff;
    // [RULE4] Four gain factors
    if (!is_diff) begin
      ch.gain = GAIN_1X;
    end else if (ch.code < 6'h20) begin
      ch.gain = low_gain ? GAIN_1X : GAIN_20X;
    end else if (low_gain) begin
      ch.gain = ch.gain_hi ? GAIN_8X : GAIN_1X;
    end else begin
      ch.gain = ch.gain_hi ? GAIN_32X : GAIN_20X;
    end
    // [RULE8] Temperature channel select
    ch.temp = (ch.code == TEMP_CHANNEL);
  end
endmodule

// *** hw/result_format.sv ***
// Saturation of the raw difference into a ten-bit result code
`timescale 1ns/1ns
module result_format
  import adc_fmt_pkg::*;
(
  // Raw converter value and conversion kind
  input wire logic signed [RAW_W-1:0] raw,
  input wire conv_kind_t kind,
  // Formatted code
  output logic [9:0] code
);
  logic signed [RAW_W-1:0] half;

  always_comb begin
    half = raw >>> 1;
    code = CODE_ZERO;
    unique case (kind)
      // [RULE6] Two's complement, scale 512
      KIND_BIPOLAR: begin
        if (half > BIP_MAX) begin
          code = CODE_BIP_MAX;
        end else if (half < BIP_MIN) begin
          code = CODE_BIP_MIN;
        end else begin
          code = half[9:0];
        end
      end
      // [RULE2] [RULE3] Unsigned, negative forced to zero
      default: begin
        if (raw < 0) begin
          code = CODE_ZERO;
        end else if (raw > UNI_MAX) begin
          code = CODE_MAX;
        end else begin
          code = raw[9:0];
        end
      end
    endcase
  end
endmodule

// *** hw/adc_fmt_top.sv ***
// Converter result formatting, reference select and register slave
// Functional notes
// [RULE1] On conversion done, result is split over low and high result bytes.
// [RULE2] Single-ended result is unsigned, ground 0x000, top 0x3FF.
// [RULE3] Unipolar differential is unsigned, negative difference forced to zero.
// [RULE4] Differential gain is 1x, 8x, 20x or 32x from the channel code.
// [RULE5] Unipolar by default; bipolar only while the bipolar select bit is one.
// [RULE6] Bipolar result is two's complement from 0x200 to 0x1FF.
// [RULE7] Result MSB in high byte is the sign in bipolar mode.
// [RULE8] Channel code 111111 selects temperature channel and enables sensor.
// [RULE9] Software picks the 1.1V reference and single conversions for temperature.
// [RULE10] Selection register: reference 7:6, align 5, channel 4:0, reset zero.
// [RULE11] Reference decode: supply, pin, 1.1V, reserved, 2.56V, 2.56V bypassed.
// [RULE12] Reference change during a conversion waits for its completion.
// [RULE13] After a reference change the next conversion takes 25 cycles.
// [RULE14] Align bit one left-adjusts result, zero right-adjusts.
// [RULE15] Toggling align re-presents result bytes at once.
// [RULE16] Channel low bits plus channel MSB choose input, pair and gain.
// [RULE17] Left: 9:2 high, 1:0 top of low; right: 9:8 bottom of high.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module adc_fmt_top
  import adc_fmt_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Register bus
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Converter core
  input wire logic CONV_BUSY,
  input wire logic CONV_DONE,
  input wire logic signed [RAW_W-1:0] RAW_CODE,
  output logic [5:0] ACTIVE_CHANNEL,
  output logic DIFF_INPUT,
  output logic [1:0] GAIN_SELECT,
  output logic BIPOLAR_ACTIVE,
  output logic [2:0] REF_SOURCE,
  output logic TEMP_SENSOR_EN,
  output logic [4:0] CONV_CYCLES,
  // Interrupt
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] select_ff, nxt_select;
  logic [7:0] csb_ff, nxt_csb;
  logic [ST_W-1:0] status_ff, nxt_status;
  logic [ST_W-1:0] mask_ff, nxt_mask;
  logic [5:0] act_chan_ff, nxt_act_chan;
  logic [2:0] act_ref_ff, nxt_act_ref;
  logic act_gain_hi_ff, nxt_act_gain_hi;
  logic act_bin_ff, nxt_act_bin;
  logic diff_ff, nxt_diff;
  gain_t gain_ff, nxt_gain;
  logic temp_ff, nxt_temp;
  ref_src_t ref_src_ff, nxt_ref_src;
  logic long_ff, nxt_long;
  logic [4:0] cyc_ff, nxt_cyc;
  logic irq_ff, nxt_irq;
  logic [9:0] result_ff, nxt_result;
  logic wait_ff, nxt_wait;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [IDX_W-1:0] idx;
  logic acc_wr;
  logic update;
  logic ref_change;
  logic [7:0] res_high, res_low;
  logic [9:0] fmt_code;
  conv_kind_t kind;
  logic [ST_W-1:0] st_clear, st_set;

  chan_if ch ();

  ////////////////////////////////////////////////////////////////////////////
  // Reference decode
  function automatic ref_src_t ref_decode(input logic [2:0] r);
    ref_src_t s;
    s = REF_SUPPLY;
    unique casez (r)
      3'b?00: s = REF_SUPPLY;
      3'b?01: s = REF_EXT_PIN;
      3'b010: s = REF_INT_1V1;
      3'b011: s = REF_RESERVED;
      3'b110: s = REF_INT_2V56;
      3'b111: s = REF_INT_2V56_BYP;
      default: s = REF_SUPPLY;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  assign ch.code = nxt_act_chan;
  assign ch.gain_hi = nxt_act_gain_hi;

  channel_decode u_dec (
    .ch(ch)
  );

  result_format u_fmt (
    .raw(RAW_CODE),
    .kind(kind),
    .code(fmt_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result presentation
  always_comb begin
    // [RULE5] Bipolar only for differential with select set
    if (!diff_ff) begin
      kind = KIND_SINGLE;
    end else if (act_bin_ff) begin
      kind = KIND_BIPOLAR;
    end else begin
      kind = KIND_UNIPOLAR;
    end
  end

  always_comb begin
    // [RULE14] [RULE15] [RULE17] Alignment applied live
    if (select_ff[SEL_ALIGN]) begin
      res_high = result_ff[9:2];
      res_low = {result_ff[1:0], 6'h00};
    end else begin
      // [RULE7] Sign bit lands in high byte
      res_high = {6'h00, result_ff[9:8]};
      res_low = result_ff[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    idx = AVS_ADDRESS[ADDR_W-1:2];
    acc_wr = AVS_WRITE && !wait_ff && AVS_BYTEENABLE[0];
    nxt_select = select_ff;
    nxt_csb = csb_ff;
    nxt_mask = mask_ff;
    st_clear = '0;
    // [RULE10] Selection register write
    if (acc_wr && idx == IDX_SELECT) begin
      nxt_select = AVS_WRITEDATA[7:0];
    end
    if (acc_wr && idx == IDX_CSB) begin
      nxt_csb = AVS_WRITEDATA[7:0];
    end
    if (acc_wr && idx == IDX_MASK) begin
      nxt_mask = AVS_WRITEDATA[ST_W-1:0];
    end
    if (acc_wr && idx == IDX_STATUS) begin
      st_clear = AVS_WRITEDATA[ST_W-1:0];
    end

    // [RULE12] Selection locked while converting
    update = !CONV_BUSY || CONV_DONE;
    nxt_act_chan = act_chan_ff;
    nxt_act_ref = act_ref_ff;
    nxt_act_gain_hi = act_gain_hi_ff;
    nxt_act_bin = act_bin_ff;
    if (update) begin
      // [RULE16] Channel MSB joins the low bits
      nxt_act_chan = {csb_ff[CSB_CHAN_MSB], select_ff[SEL_CHAN_MSB:0]};
      nxt_act_ref = {csb_ff[CSB_REF_HIGH], select_ff[SEL_REF_MSB:SEL_REF_LSB]};
      nxt_act_gain_hi = csb_ff[CSB_GAIN_HI];
      nxt_act_bin = csb_ff[CSB_BIN];
    end
    ref_change = (nxt_act_ref != act_ref_ff);

    // [RULE11] Reference decode
    nxt_ref_src = ref_decode(nxt_act_ref);
    nxt_diff = ch.diff;
    nxt_gain = ch.gain;
    // [RULE8] Sensor enable from channel code
    nxt_temp = ch.temp;

    // [RULE13] Long conversion after reference change
    nxt_long = long_ff;
    if (CONV_DONE) begin
      nxt_long = 1'b0;
    end
    if (ref_change) begin
      nxt_long = 1'b1;
    end
    nxt_cyc = nxt_long ? CONV_LONG_CYC : CONV_NORMAL_CYC;

    // [RULE1] Capture result on completion
    nxt_result = result_ff;
    if (CONV_DONE) begin
      nxt_result = fmt_code;
    end

    // Sticky events, set beats clear
    st_set = '0;
    st_set[ST_DONE] = CONV_DONE;
    st_set[ST_REF_UPD] = ref_change;
    nxt_status = (status_ff & ~st_clear) | st_set;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  // Bus answer one cycle after request
  always_comb begin
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    if (wait_ff && (AVS_READ || AVS_WRITE)) begin
      nxt_wait = 1'b0;
    end
    if (wait_ff && AVS_READ) begin
      nxt_rdata = '0;
      unique case (idx)
        IDX_RES_LOW: nxt_rdata[7:0] = res_low;
        IDX_RES_HIGH: nxt_rdata[7:0] = res_high;
        IDX_SELECT: nxt_rdata[7:0] = select_ff;
        IDX_CSB: nxt_rdata[7:0] = csb_ff;
        IDX_STATUS: nxt_rdata[ST_W-1:0] = status_ff;
        IDX_MASK: nxt_rdata[ST_W-1:0] = mask_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  // Software registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      select_ff <= RESET_SELECT;
      csb_ff <= RESET_CSB;
      mask_ff <= RESET_MASK;
    end else begin
      select_ff <= nxt_select;
      csb_ff <= nxt_csb;
      mask_ff <= nxt_mask;
    end
  end

  // Locked selection and decode
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      act_chan_ff <= 6'h00;
      act_ref_ff <= 3'h0;
      act_gain_hi_ff <= 1'b0;
      act_bin_ff <= 1'b0;
      diff_ff <= 1'b0;
      gain_ff <= GAIN_1X;
      temp_ff <= 1'b0;
      ref_src_ff <= REF_SUPPLY;
    end else begin
      act_chan_ff <= nxt_act_chan;
      act_ref_ff <= nxt_act_ref;
      act_gain_hi_ff <= nxt_act_gain_hi;
      act_bin_ff <= nxt_act_bin;
      diff_ff <= nxt_diff;
      gain_ff <= nxt_gain;
      temp_ff <= nxt_temp;
      ref_src_ff <= nxt_ref_src;
    end
  end

  // Conversion, result and events
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_ff <= RESET_STATUS;
      long_ff <= 1'b0;
      cyc_ff <= CONV_NORMAL_CYC;
      irq_ff <= 1'b0;
      result_ff <= CODE_ZERO;
    end else begin
      status_ff <= nxt_status;
      long_ff <= nxt_long;
      cyc_ff <= nxt_cyc;
      irq_ff <= nxt_irq;
      result_ff <= nxt_result;
    end
  end

  // Bus answer
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;
  assign ACTIVE_CHANNEL = act_chan_ff;
  assign DIFF_INPUT = diff_ff;
  assign GAIN_SELECT = gain_ff;
  assign BIPOLAR_ACTIVE = act_bin_ff;
  assign REF_SOURCE = ref_src_ff;
  assign TEMP_SENSOR_EN = temp_ff;
  assign CONV_CYCLES = cyc_ff;
  assign IRQ = irq_ff;
endmodule

// *** testbench/adc_fmt_props.sv ***
// Port checker for the result and reference select block
`timescale 1ns/1ns
module adc_fmt_props
  import adc_fmt_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Register bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Converter core
  input wire logic CONV_BUSY,
  input wire logic CONV_DONE,
  input wire logic [5:0] ACTIVE_CHANNEL,
  input wire logic DIFF_INPUT,
  input wire logic [1:0] GAIN_SELECT,
  input wire logic [2:0] REF_SOURCE,
  input wire logic TEMP_SENSOR_EN,
  input wire logic [4:0] CONV_CYCLES
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence req_s;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence locked_s;
    CONV_BUSY && !CONV_DONE;
  endsequence
  bus_answer_a: assert property (req_s |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chan_lock_a: assert property (locked_s |=> $stable(ACTIVE_CHANNEL))
    else $error("channel changed during conversion");
  ref_lock_a: assert property (locked_s |=> $stable(REF_SOURCE))
    else $error("reference changed during conversion");
  long_conv_a: assert property (
    $changed(REF_SOURCE) |-> ##[0:1] CONV_CYCLES == CONV_LONG_CYC)
    else $error("no long conversion after reference change");
  temp_dec_a: assert property (TEMP_SENSOR_EN == (ACTIVE_CHANNEL == TEMP_CHANNEL))
    else $error("sensor enable does not match channel");
  single_gain_a: assert property (!DIFF_INPUT |-> GAIN_SELECT == GAIN_1X)
    else $error("gain set on single-ended input");
  ref_range_a: assert property (REF_SOURCE <= REF_INT_2V56_BYP)
    else $error("reference source out of range");
endmodule
bind adc_fmt_top adc_fmt_props u_props (.CORE_CLK, .RST_B, .AVS_READ, .AVS_WRITE,
  .AVS_WAITREQUEST, .CONV_BUSY, .CONV_DONE, .ACTIVE_CHANNEL, .DIFF_INPUT,
  .GAIN_SELECT, .REF_SOURCE, .TEMP_SENSOR_EN, .CONV_CYCLES);

// *** testbench/conv_core_model.sv ***
// Behavioural converter core answering start pulses
`timescale 1ns/1ns
module conv_core_model
  import adc_fmt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Start request
  input wire logic start,
  input wire logic [7:0] extra,
  input wire logic signed [RAW_W-1:0] value,
  input wire logic [4:0] cycles,
  // Core side
  output logic busy,
  output logic done,
  output logic signed [RAW_W-1:0] raw
);
  int cnt;
  logic signed [RAW_W-1:0] held;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      done <= 1'b0;
      raw <= 12'sh000;
      cnt <= 0;
      held <= 12'sh000;
    end else begin
      done <= 1'b0;
      raw <= ~raw;
      if (!busy && start) begin
        busy <= 1'b1;
        cnt <= int'(cycles) + int'(extra) - 2;
        held <= value;
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end else if (busy && !done) begin
        done <= 1'b1;
        raw <= held;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the result and reference select block
`timescale 1ns/1ns
module tb;
  import adc_fmt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h1;
  logic start = 1'b0;
  logic [7:0] extra = 8'h00;
  logic signed [RAW_W-1:0] value = 12'sh000;
  logic [31:0] rdata;
  logic waitreq, busy, done, diff, bip, temp, irq, b;
  logic signed [RAW_W-1:0] raw, v;
  logic [5:0] act;
  logic [1:0] gain;
  logic [2:0] refs;
  logic [4:0] cyc;
  logic [7:0] sel, q;
  logic [10:0] e;
  int n_mismatch = 0;
  int compares = 0;
  logic [5:0] ids [7] = '{IDX_SELECT, IDX_CSB, IDX_STATUS, IDX_MASK, IDX_RES_LOW,
    IDX_RES_HIGH, 6'h3C};
  logic [10:0] chans [7] = '{11'h000, 11'h16C, 11'h188, 11'h40C, 11'h41E, 11'h43A, 11'h7E1};
  logic [12:0] corners [6] = '{13'h1800, 13'h17FF, 13'h1FFE, 13'h0FFF, 13'h0400, 13'h1000};
  always #25 clk = ~clk;
  adc_fmt_top u_dut (.CORE_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .CONV_BUSY(busy), .CONV_DONE(done), .RAW_CODE(raw),
    .ACTIVE_CHANNEL(act), .DIFF_INPUT(diff), .GAIN_SELECT(gain), .BIPOLAR_ACTIVE(bip),
    .REF_SOURCE(refs), .TEMP_SENSOR_EN(temp), .CONV_CYCLES(cyc), .IRQ(irq));
  conv_core_model u_core (.clk(clk), .rst_b(rst_b), .start(start), .extra(extra),
    .value(value), .cycles(cyc), .busy(busy), .done(done), .raw(raw));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) begin
      n_mismatch++;
      tally_and_finish();
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic go(input logic signed [RAW_W-1:0] x, input logic [7:0] slow);
    @(posedge clk);
    start <= 1'b1;
    value <= x;
    extra <= slow;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic fin();
    int n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask
  function automatic logic [9:0] fmt(input logic signed [RAW_W-1:0] r, input logic bp);
    logic signed [RAW_W-1:0] h;
    h = r >>> 1;
    if (bp) return (h > 12'sh1FF) ? 10'h1FF : (h < 12'shE00) ? 10'h200 : h[9:0];
    return r[11] ? 10'h000 : (r > 12'sh3FF) ? 10'h3FF : r[9:0];
  endfunction
  function automatic logic [2:0] refx(input logic [2:0] k);
    return (k[2] && k[1]) ? {2'b10, k[0]} : {1'b0, k[1:0]};
  endfunction
  task automatic chk_res(input logic [9:0] x);
    for (int a = 0; a < 2; a++) begin
      xfer(1'b1, IDX_SELECT, {sel[7:6], a[0], sel[4:0]});
      xfer(1'b0, IDX_RES_HIGH, 8'h00);
      check("res_high", a[0] ? x[9:2] : {6'h00, x[9:8]}, q);
      xfer(1'b0, IDX_RES_LOW, 8'h00);
      check("res_low", a[0] ? {x[1:0], 6'h00} : x[7:0], q);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(45));
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ids[i]) begin
      xfer(1'b0, ids[i], 8'h00);
      check("reset_value", 10'h000, q);
    end
    repeat (4) begin
      sel = 8'($urandom);
      xfer(1'b1, IDX_SELECT, sel);
      xfer(1'b0, IDX_SELECT, 8'h00);
      check("select_rw", sel, q);
    end
    be <= 4'h0;
    xfer(1'b1, IDX_SELECT, ~sel);
    be <= 4'h1;
    xfer(1'b0, IDX_SELECT, 8'h00);
    check("select_be", sel, q);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, IDX_CSB, {3'b000, k[2], 4'h0});
      sel = {k[1:0], 6'h00};
      xfer(1'b1, IDX_SELECT, sel);
      repeat (3) @(posedge clk);
      check("ref_source", refx(k[2:0]), refs);
      if (k > 0) check("long_cycles", CONV_LONG_CYC, cyc);
    end
    go(12'sh123, 8'h14);
    sel = 8'h80;
    xfer(1'b1, IDX_SELECT, sel);
    repeat (3) @(posedge clk);
    check("ref_held", REF_INT_2V56_BYP, refs);
    fin();
    check("ref_after", REF_INT_2V56, refs);
    check("long_again", CONV_LONG_CYC, cyc);
    go(12'sh010, 8'h00);
    fin();
    check("normal_cycles", CONV_NORMAL_CYC, cyc);
    foreach (chans[i]) begin
      e = chans[i];
      b = 1'($urandom);
      v = 12'($urandom);
      xfer(1'b1, IDX_CSB, {b, e[4], 2'b00, e[10], 3'b000});
      sel = {2'b10, 1'b0, e[9:5]};
      xfer(1'b1, IDX_SELECT, sel);
      go(v, 8'h00);
      fin();
      check("channel", e[10:5], act);
      check("diff", e[3], diff);
      check("gain", e[2:1], gain);
      check("temp", e[0], temp);
      check("bipolar", b, bip);
      chk_res(fmt(v, b & e[3]));
    end
    sel = 8'h8B;
    foreach (corners[i]) begin
      xfer(1'b1, IDX_CSB, {corners[i][12], 7'h00});
      xfer(1'b1, IDX_SELECT, sel);
      go(corners[i][11:0], 8'h00);
      fin();
      chk_res(fmt(corners[i][11:0], corners[i][12]));
    end
    xfer(1'b1, IDX_STATUS, 8'h03);
    xfer(1'b1, IDX_MASK, 8'h01);
    repeat (2) @(posedge clk);
    check("irq_clear", 1'b0, irq);
    go(12'sh055, 8'h00);
    fin();
    check("irq_set", 1'b1, irq);
    xfer(1'b0, IDX_STATUS, 8'h00);
    check("status_done", 1'b1, q[0]);
    check("status_ref", 1'b0, q[1]);
    xfer(1'b1, IDX_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    check("irq_w1c", 1'b0, irq);
    xfer(1'b1, IDX_MASK, 8'h00);
    go(12'sh055, 8'h00);
    fin();
    check("irq_masked", 1'b0, irq);
    // Align toggled while a conversion runs
    go(12'sh3FF, 8'h14);
    chk_res(fmt(12'sh055, 1'b1));
    fin();
    // Mid-run reset with a pending interrupt
    xfer(1'b1, IDX_MASK, 8'h01);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    check("irq_reset", 1'b0, irq);
    foreach (ids[i]) begin
      xfer(1'b0, ids[i], 8'h00);
      check("rerun_reset", 10'h000, q);
    end
    tally_and_finish();
  end
endmodule
